// >>> hw/tpcg_debounce.sv
// Step pushbutton debounce latch with one-shot step pulse
`timescale 1ns/1ns
module tpcg_debounce
(
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  // Switch contacts, high while the contact is made
  input  wire logic no_made_in,
  input  wire logic nc_made_in,
  // Step request
  output logic      step_pulse_out
);
  import tpcg_pkg::*;

  typedef struct packed {
    logic latch;
    logic pulse;
  } tpcg_deb_s;

  tpcg_deb_s st_reg;
  tpcg_deb_s st_next;

  always_comb
  begin
    st_next       = st_reg;
    // Pulse freezes too, so a press landing as the enable drops is not lost
    if (ce_in)
    begin
      // Both or neither contact made means the arm is in flight: hold
      if (no_made_in && !nc_made_in)
      begin
        st_next.latch = 1'b1;
      end
      else if (nc_made_in && !no_made_in)
      begin
        st_next.latch = 1'b0;
      end
      st_next.pulse = st_next.latch && !st_reg.latch;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign step_pulse_out = st_reg.pulse;

  press_sets_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && no_made_in && !nc_made_in && !st_reg.latch) |=> (step_pulse_out && st_reg.latch))
    else $error("press did not raise one step pulse");
  pulse_single_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && step_pulse_out) |=> !step_pulse_out)
    else $error("step pulse longer than one cycle");
  bounce_hold_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && no_made_in == nc_made_in) |=> ($stable(st_reg.latch) && !step_pulse_out))
    else $error("latch moved while contacts ambiguous");
endmodule : tpcg_debounce

// >>> hw/tpcg_pkg.sv
// Shared constants and types for the two-phase clock generator
package tpcg_pkg;
  // Ring and division
  localparam int          RING_W      = 7;
  localparam int          DIV7        = 7;
  localparam int          DIV8        = 8;
  localparam logic [6:0]  RING_RST    = 7'h01;
  localparam logic [2:0]  RING_HI_CLR = 3'h0;
  // Phase decode masks: seven-stage and four-stage ring
  localparam logic [6:0]  P1_MASK7    = 7'h03;
  localparam logic [6:0]  P2_MASK7    = 7'h30;
  localparam logic [6:0]  P1_MASK4    = 7'h01;
  localparam logic [6:0]  P2_MASK4    = 7'h04;
  // Timing
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          STOP_RESP_NS  = 1000;
  localparam int          STOP_RESP_CYC = STOP_RESP_NS / CLK_PERIOD_NS;
  // Single-step handshake states
  typedef enum logic [2:0]
  {
    ST_HALT     = 3'b001,
    ST_RUN_ONE  = 3'b010,
    ST_WAIT_ACK = 3'b100
  } tpcg_step_e;
endpackage : tpcg_pkg

// >>> hw/tpcg_top.sv
// Two-phase clock generator: ring divider, phase decode, reset and single step
// Operation
// - Mode high divides by 7, low by 8
// - Divide-by-7 circulates one through seven stages
// - Divide-by-8 halves, then four-stage ring
// - Divide-by-8: all four intervals quarter period
// - Divide-by-7: pulses and gap 2/7, gap 1/7
// - Phases decoded from ring, mode selects decode
// - MOS and TTL outputs carry identical phases
// - External master frequency replaces the crystal
// - Reset out low one cycle after timing input low, held while ce_in low
// - Reset output is active low, system-wide
// - Stop handshake lets exactly one instruction run
// - Step button debounced: one press, one step
// - Stop output follows acknowledge within 1 us
`timescale 1ns/1ns
module tpcg_top
  import tpcg_pkg::*;
(
  // Master clock (ref_clk_in, crystal or external source) and reset
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  // Configuration and reset timing
  input  wire logic mode_in,
  input  wire logic reset_timing_in,
  // Single step
  input  wire logic no_made_in,
  input  wire logic nc_made_in,
  input  wire logic stop_ack_in,
  output logic      stop_out,
  // Clock and reset outputs
  output logic      phase_one_out,
  output logic      phase_two_out,
  output logic      phase_one_logic_clock_out,
  output logic      phase_two_logic_clock_out,
  output logic      system_reset_n_out
);
  import tpcg_pkg::*;

  typedef struct packed {
    logic [RING_W-1:0] ring;
    logic              pre;
    logic              p1_mos;
    logic              p2_mos;
    logic              p1_ttl;
    logic              p2_ttl;
    logic              rst_n;
    logic              stop;
    tpcg_step_e        step;
  } tpcg_state_s;

  tpcg_state_s st_reg;
  tpcg_state_s st_next;
  logic        step_pulse;

  tpcg_debounce u_debounce
  (
    .ref_clk_in     (ref_clk_in),
    .arst_n_in      (arst_n_in),
    .ce_in          (ce_in),
    .no_made_in     (no_made_in),
    .nc_made_in     (nc_made_in),
    .step_pulse_out (step_pulse)
  );

  always_comb
  begin
    st_next = st_reg;
    if (ce_in)
    begin
      // The master clock is the only clock; an external source simply drives it
      if (mode_in)
      begin
        st_next.pre  = 1'b0;
        st_next.ring = {st_reg.ring[RING_W-2:0], st_reg.ring[RING_W-1]};
      end
      else
      begin
        st_next.pre = !st_reg.pre;
        if (st_reg.ring[RING_W-1:4] != RING_HI_CLR)
        begin
          // Leaving divide-by-7 from an upper stage: restart rather than lose the one
          st_next.ring = RING_RST;
        end
        else if (st_reg.pre)
        begin
          st_next.ring = {RING_HI_CLR, st_reg.ring[2:0], st_reg.ring[3]};
        end
      end
      // Decode from next ring so registered outputs line up with the ring
      if (mode_in)
      begin
        st_next.p1_mos = |(st_next.ring & P1_MASK7);
        st_next.p2_mos = |(st_next.ring & P2_MASK7);
      end
      else
      begin
        st_next.p1_mos = |(st_next.ring & P1_MASK4);
        st_next.p2_mos = |(st_next.ring & P2_MASK4);
      end
      st_next.p1_ttl = st_next.p1_mos;
      st_next.p2_ttl = st_next.p2_mos;
      st_next.rst_n  = reset_timing_in;
      case (st_reg.step)
        ST_HALT:
        begin
          st_next.stop = 1'b1;
          if (step_pulse && stop_ack_in)
          begin
            st_next.step = ST_RUN_ONE;
            st_next.stop = 1'b0;
          end
        end
        ST_RUN_ONE:
        begin
          if (!stop_ack_in)
          begin
            // Processor left the stop state: re-request stop next edge
            st_next.step = ST_WAIT_ACK;
            st_next.stop = 1'b1;
          end
        end
        ST_WAIT_ACK:
        begin
          // Presses during the instruction are dropped, not queued
          st_next.stop = 1'b1;
          if (stop_ack_in)
          begin
            st_next.step = ST_HALT;
          end
        end
        default:
        begin
          st_next.step = ST_HALT;
          st_next.stop = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_reg      <= '0;
      st_reg.ring <= RING_RST;
      st_reg.stop <= 1'b1;
      st_reg.step <= ST_HALT;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign phase_one_out             = st_reg.p1_mos;
  assign phase_two_out             = st_reg.p2_mos;
  assign phase_one_logic_clock_out = st_reg.p1_ttl;
  assign phase_two_logic_clock_out = st_reg.p2_ttl;
  assign system_reset_n_out        = st_reg.rst_n;
  assign stop_out                  = st_reg.stop;

  sequence p1_rise7_s;
    $rose(phase_one_out) && mode_in && ce_in;
  endsequence
  sequence p1_hold7_s;
    mode_in && ce_in && phase_one_out;
  endsequence
  sequence p1_rise8_s;
    $rose(phase_one_out) && !mode_in && ce_in;
  endsequence

  ring_onehot_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $onehot(st_reg.ring))
    else $error("ring does not hold exactly one token");
  div7_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && mode_in && st_reg.ring[6]) |=> st_reg.ring[0])
    else $error("seven-stage ring did not wrap");
  div8_hold_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && !mode_in && !st_reg.pre && st_reg.ring[RING_W-1:4] == RING_HI_CLR) |=> $stable(st_reg.ring))
    else $error("four-stage ring advanced on half-rate off cycle");
  div8_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && !mode_in && st_reg.pre && st_reg.ring[3]) |=> st_reg.ring[0])
    else $error("four-stage ring did not wrap");
  phase_width7_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    p1_rise7_s ##1 p1_hold7_s |=> !phase_one_out)
    else $error("phase one width not two cycles in divide-by-7");
  phase_width8_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    p1_rise8_s ##1 (!mode_in && ce_in)[*2] |=> (!phase_one_out && !phase_two_out) ##0 (!mode_in && ce_in) ##1
      (!mode_in && ce_in) |=> phase_two_out)
    else $error("divide-by-8 phase spacing not a quarter period");
  no_overlap_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    !(phase_one_out && phase_two_out))
    else $error("phases overlap");
  ttl_match_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (phase_one_logic_clock_out == phase_one_out) && (phase_two_logic_clock_out == phase_two_out))
    else $error("logic-level clocks differ from MOS clocks");
  reset_follow_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    ce_in |=> (system_reset_n_out == $past(reset_timing_in)))
    else $error("reset output does not follow timing input");
  step_release_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && st_reg.step == ST_HALT && step_pulse && stop_ack_in) |=> !stop_out)
    else $error("step press did not release stop");
  stop_resp_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && st_reg.step == ST_RUN_ONE && !stop_ack_in) |=> stop_out)
    else $error("stop not re-asserted after acknowledge dropped");
  wait_stop_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (st_reg.step == ST_WAIT_ACK) |-> stop_out)
    else $error("stop released before the processor halted again");
  one_step_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && st_reg.step == ST_WAIT_ACK) |=> (st_reg.step != ST_RUN_ONE))
    else $error("second instruction granted without a new press");
  gap_short7_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && mode_in && st_reg.ring[6]) |=> (phase_one_out && !phase_two_out))
    else $error("divide-by-7 gap from phase two to phase one not one cycle");
  p2_hold8_a: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    (ce_in && !mode_in && st_reg.ring[2] && !st_reg.pre) |=> phase_two_out)
    else $error("divide-by-8 phase two not held for its second cycle");
endmodule : tpcg_top

// >>> tb/tpcg_cpu_model.sv
// Behavioural processor side of the stop handshake, counts executed instructions
`timescale 1ns/1ns
module tpcg_cpu_model
#(
  parameter int INSTR_CYC = 8
)
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  // Stop handshake
  input  wire logic        stop_in,
  output logic             stop_ack_out,
  output logic [15:0]      instr_count_out
);
  logic       busy_reg;
  logic [7:0] tmr_reg;

  // A running instruction always completes; stop is only honoured at its end
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      stop_ack_out    <= 1'b1;
      busy_reg        <= 1'b0;
      tmr_reg         <= 8'h00;
      instr_count_out <= 16'h0000;
    end
    else if (busy_reg)
    begin
      tmr_reg <= tmr_reg + 8'h01;
      if (tmr_reg == 8'(INSTR_CYC - 1))
      begin
        tmr_reg         <= 8'h00;
        instr_count_out <= instr_count_out + 16'h0001;
        busy_reg        <= !stop_in;
        stop_ack_out    <= stop_in;
      end
    end
    else if (stop_ack_out && !stop_in)
    begin
      stop_ack_out <= 1'b0;
      busy_reg     <= 1'b1;
    end
  end
endmodule : tpcg_cpu_model

// >>> tb/two_phase_clock_generator_bench.sv
// Self-checking bench for the two-phase clock generator
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module two_phase_clock_generator_bench;
  import tpcg_pkg::*;
  logic        ref_clk_in      = 1'b0;
  logic        arst_n_in       = 1'b0;
  logic        ce_in           = 1'b1;
  logic        mode_in         = 1'b1;
  logic        reset_timing_in = 1'b1;
  logic        no_made_in      = 1'b0;
  logic        nc_made_in      = 1'b1;
  logic        stop_ack, stop_out, p1, p2, p1t, p2t, sys_rst_n;
  logic [15:0] instr_count;
  int          n_mismatch      = 0;
  int          total_checks    = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  tpcg_top dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .mode_in(mode_in),
    .reset_timing_in(reset_timing_in), .no_made_in(no_made_in), .nc_made_in(nc_made_in),
    .stop_ack_in(stop_ack), .stop_out(stop_out), .phase_one_out(p1), .phase_two_out(p2),
    .phase_one_logic_clock_out(p1t), .phase_two_logic_clock_out(p2t), .system_reset_n_out(sys_rst_n));
  tpcg_cpu_model #(.INSTR_CYC(8)) cpu (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .stop_in(stop_out),
    .stop_ack_out(stop_ack), .instr_count_out(instr_count));

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task tick;
    @(posedge ref_clk_in);
    #1;
  endtask : tick

  // Bounded wait on stop_out (0), stop_ack (1) or phase one (2)
  task wait_sig(input int sel, input logic val, input int lim);
    int i;
    for (i = 0; i <= lim; i++)
    begin
      if ((sel == 0 ? stop_out : sel == 1 ? stop_ack : p1) === val)
        return;
      tick();
    end
    n_mismatch++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, ~val, val);
    print_verdict();
  endtask : wait_sig

  task check_phases(input logic mode, input int period);
    int i;
    mode_in = mode;
    repeat (20) tick();
    wait_sig(2, 1'b0, 20);
    wait_sig(2, 1'b1, 20);
    for (i = 0; i < 2 * period; i++)
    begin
      `CHK(p1, logic'((i % period) < 2))
      `CHK(p2, logic'((i % period) == 4 || (i % period) == 5))
      `CHK({p1t, p2t}, {p1, p2})
      tick();
    end
    $display("phase test done, period %0d", period);
  endtask : check_phases

  // Clock enable low must hold every output
  task check_freeze;
    logic [5:0] held;
    held = {p1, p2, p1t, p2t, sys_rst_n, stop_out};
    ce_in = 1'b0;
    reset_timing_in = 1'b0;
    repeat (4)
    begin
      tick();
      `CHK({p1, p2, p1t, p2t, sys_rst_n, stop_out}, held)
    end
    reset_timing_in = 1'b1;
    ce_in = 1'b1;
    $display("freeze test done");
  endtask : check_freeze

  task check_reset_out;
    reset_timing_in = 1'b0;
    tick();
    `CHK(sys_rst_n, 1'b0)
    reset_timing_in = 1'b1;
    tick();
    `CHK(sys_rst_n, 1'b1)
    $display("reset output test done");
  endtask : check_reset_out

  // Button held well past the step, with a bounce: still exactly one instruction
  task check_step;
    logic [15:0] c0;
    c0 = instr_count;
    no_made_in = 1'b1;
    nc_made_in = 1'b0;
    wait_sig(0, 1'b0, 10);
    no_made_in = 1'b0;
    repeat (2) tick();
    no_made_in = 1'b1;
    wait_sig(1, 1'b0, 10);
    wait_sig(0, 1'b1, STOP_RESP_CYC);
    wait_sig(1, 1'b1, 50);
    repeat (30) tick();
    `CHK(instr_count, c0 + 16'h0001)
    `CHK(stop_out, 1'b1)
    no_made_in = 1'b0;
    nc_made_in = 1'b1;
    repeat (2) tick();
    $display("single step test done");
  endtask : check_step

  initial
  begin
    repeat (8) tick();
    `CHK({p1, p2, p1t, p2t, sys_rst_n, stop_out}, 6'h01)
    arst_n_in = 1'b1;
    check_phases(1'b1, 7);
    check_phases(1'b0, 8);
    check_freeze();
    check_reset_out();
    check_step();
    check_step();
    print_verdict();
  end
endmodule : two_phase_clock_generator_bench
